// ---- core/vsd_detector.sv ----
// Composite sync slicer and vertical sync detector with field parity output.
//
// How it works
// - csync_n reproduces only the sync part of the input, picture removed.
// - Sync tips set a tracked reference; slice a fixed offset above it.
// - Integrator charges only while sync is active, discharges otherwise.
// - Two comparators, serration and default, read the same integrator value.
// - Serration comparator result is captured at each internal sync falling edge.
// - Captured result ORed with default comparator sets the vertical latch.
// - Latch clears after eight oscillator cycles from a divide-by-eight counter.
// - One timing_set input scales oscillator period and integrator charge rate.
// - The vertical output is the latch itself, starting at the serration.
// - Too slow a charge rate gives no vertical pulse at all.
// - After the latch clears, a later serration may set it again.
// - Without serrations, the default threshold sets the latch.
// - End of input vertical sync can retrigger a second pulse via capture.
// - field_odd is low in even fields, high in odd, updated per pulse.
`timescale 1ns/1ps
module vsd_detector
    import vsd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [VIDEO_W-1:0] video_in,
    input wire vsd_cfg_t cfg,
    output logic csync_n,
    output logic vsync,
    output logic field_odd
);

    logic [VIDEO_W-1:0] video_q;
    logic [VIDEO_W-1:0] tip;
    logic [LEAK_W-1:0] leak_cnt;
    logic [VIDEO_W:0] slice_level;
    logic sync_act;
    logic sync_q;
    logic sync_fall;
    logic sync_rise;
    logic [TSET_W-1:0] chg_cnt;
    logic charge_tick;
    logic [INTEG_W-1:0] integ;
    logic cmp_serr;
    logic cmp_def;
    logic cmp_def_q;
    logic edge_q;
    logic edge_strobe;
    logic set_req;
    logic osc_done;
    logic [GAP_W-1:0] gap_cnt;
    logic gap_long;
    logic parity_q;
    logic [OSC_PERIOD_W-1:0] osc_period;

    // Input sample register; the pin is synchronous to clk_sys.
    // It resets to the brightest code so that the clamp cannot take the reset
    // value for a sync tip and then need thousands of cycles to creep back up.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            video_q <= '1;
        else
            video_q <= video_in;
    end

    // Tip clamp: snaps down to any lower sample, creeps up slowly otherwise,
    // like a fast clamp current against a small discharge current.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            leak_cnt <= '0;
        else if (leak_cnt == LEAK_W'(CLAMP_LEAK_CYCLES - 1))
            leak_cnt <= '0;
        else
            leak_cnt <= leak_cnt + LEAK_W'(1);
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            tip <= TIP_RESET;
        else if (video_q < tip)
            tip <= video_q;
        else if (leak_cnt == LEAK_W'(CLAMP_LEAK_CYCLES - 1) && tip != TIP_RESET)
            tip <= tip + VIDEO_W'(1);
    end

    // The offset is a fixed code, so it does not grow with input amplitude.
    assign slice_level = {1'b0, tip} + SLICE_OFFSET_CODE;
    assign sync_act = ({1'b0, video_q} <= slice_level);
    assign sync_fall = sync_q && !sync_act;
    assign sync_rise = !sync_q && sync_act;

    // The reset sample slices as sync, so the delayed copy starts high too and
    // no false edge follows reset.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            sync_q <= 1'b1;
        else
            sync_q <= sync_act;
    end

    // Composite sync output, negative going like the source.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            csync_n <= 1'b1;
        else
            csync_n <= !sync_act;
    end

    // Charge prescaler: a larger timing_set charges more slowly.
    assign charge_tick = sync_act && (({1'b0, chg_cnt} + (TSET_W + 1)'(1))
        >= {1'b0, cfg.timing_set});

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            chg_cnt <= '0;
        else if (!sync_act || charge_tick)
            chg_cnt <= '0;
        else
            chg_cnt <= chg_cnt + TSET_W'(1);
    end

    // Integrator as a saturating up/down counter.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            integ <= INTEG_RESET;
        else if (sync_act)
        begin
            if (charge_tick && integ != INTEG_MAX)
                integ <= integ + INTEG_W'(1);
        end
        else if (integ > INTEG_DISCHARGE)
            integ <= integ - INTEG_DISCHARGE;
        else
            integ <= '0;
    end

    // Both comparators look at the same integrator value.
    assign cmp_serr = (integ >= cfg.serration_detect_threshold);
    assign cmp_def = (integ >= cfg.default_detect_threshold);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            cmp_def_q <= 1'b0;
        else
            cmp_def_q <= cmp_def;
    end

    // Edge register: the start of a serration, and also the trailing edge of
    // a vertical sync interval, is a falling edge of internal sync.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            edge_q <= 1'b0;
        else if (sync_fall)
            edge_q <= cmp_serr;
    end

    // Strobe marks the cycle after a capture so that a held high capture sets
    // the latch only once per serration, not again as soon as it clears.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            edge_strobe <= 1'b0;
        else
            edge_strobe <= sync_fall;
    end

    // The default path fires on the rising crossing of the upper threshold.
    assign set_req = !vsync && ((edge_strobe && edge_q) || (cmp_def && !cmp_def_q));

    // Vertical pulse latch, which is also the vertical output.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            vsync <= 1'b0;
        else if (osc_done)
            vsync <= 1'b0;
        else if (set_req)
            vsync <= 1'b1;
    end

    assign osc_period = {cfg.timing_set, OSC_SHIFT'(0)};

    vsd_osc_div #(
        .PW(OSC_PERIOD_W)
    ) u_osc (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .run(vsync),
        .period(osc_period),
        .tick(),
        .done(osc_done)
    );

    // Field tracker: a long gap between syncs clears the parity flop, while
    // the short gaps of the vertical interval toggle it on each sync.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            gap_cnt <= '0;
        else if (sync_act)
            gap_cnt <= '0;
        else if (gap_cnt != '1)
            gap_cnt <= gap_cnt + GAP_W'(1);
    end

    assign gap_long = (gap_cnt >= cfg.field_gap_threshold);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            parity_q <= 1'b0;
        else if (sync_rise)
            parity_q <= gap_long ? 1'b0 : !parity_q;
    end

    // Field output changes only when a vertical pulse starts.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            field_odd <= 1'b0;
        else if (set_req)
            field_odd <= parity_q;
    end

    // Checking aid only: counts how long the latch has been set.
    logic [OSC_PERIOD_W+OSC_DIV_W-1:0] pulse_len;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            pulse_len <= '0;
        else if (!vsync)
            pulse_len <= '0;
        else
            pulse_len <= pulse_len + (OSC_PERIOD_W + OSC_DIV_W)'(1);
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_csync_copy: assert property ($past(nrst) |-> csync_n == !$past(sync_act))
        else $error("csync_n does not follow the sliced sync");

    a_tip_clamp: assert property ((video_q < tip) |=> (tip == $past(video_q)))
        else $error("tip reference did not clamp to a lower sample");

    a_slice_fixed: assert property (sync_act |-> ({1'b0, video_q} <= {1'b0, tip} + 9'h009))
        else $error("sync sliced above the fixed offset");

    a_integ_discharge: assert property ((!sync_act && integ != 16'h0000)
        |=> (integ < $past(integ)))
        else $error("integrator failed to discharge outside sync");

    a_integ_charge_only: assert property (sync_act |=> (integ >= $past(integ)))
        else $error("integrator fell while sync was active");

    a_cmp_order: assert property ((cmp_def && cfg.serration_detect_threshold
        <= cfg.default_detect_threshold) |-> cmp_serr)
        else $error("default comparator high while serration comparator low");

    a_edge_capture: assert property (sync_fall |=> (edge_q == $past(cmp_serr)))
        else $error("edge register missed the serration capture");

    a_latch_set: assert property (set_req && !osc_done |=> vsync ##1 vsync)
        else $error("vertical latch not set by request");

    a_pulse_end: assert property (osc_done |=> !vsync)
        else $error("vertical latch not cleared after eight oscillator cycles");

    a_vsync_cause: assert property ($rose(vsync) |-> $past(edge_strobe && edge_q)
        || $past(cmp_def && !cmp_def_q))
        else $error("vertical pulse started without a cause");

    a_no_pulse_low: assert property ((!vsync && !cmp_serr && !cmp_def && !edge_q)
        |=> !vsync)
        else $error("vertical pulse without threshold crossing");

    a_field_hold: assert property (!$past(set_req) |-> $stable(field_odd))
        else $error("field output changed outside a pulse start");

    a_edge_hold: assert property (!sync_fall |=> $stable(edge_q))
        else $error("edge register changed without a sync falling edge");

    a_retrigger: assert property ((!vsync && edge_strobe && edge_q) |=> vsync)
        else $error("captured serration did not set the idle latch");

    a_default_set: assert property ((!vsync && cmp_def && !cmp_def_q) |=> vsync)
        else $error("default threshold crossing did not set the idle latch");

    a_field_load: assert property (set_req |=> (field_odd == $past(parity_q)))
        else $error("field output not loaded from the parity flop at pulse start");

    a_pulse_width: assert property ($fell(vsync) |->
        (pulse_len == {cfg.timing_set, (OSC_SHIFT + OSC_DIV_W)'(0)}))
        else $error("vertical pulse width is not eight oscillator periods");

    c_serration_start: cover property (sync_fall && cmp_serr && !cmp_def ##2 $rose(vsync));
    c_default_start: cover property ($rose(cmp_def) && !vsync ##1 $rose(vsync));
    c_second_pulse: cover property ($fell(vsync) ##[1:1000] $rose(vsync));
    c_field_odd: cover property ($rose(field_odd));

endmodule // vsd_detector

// ---- core/vsd_osc_div.sv ----
// Gated pulse-width oscillator followed by a divide-by-eight counter.
`timescale 1ns/1ps
module vsd_osc_div
    import vsd_pkg::*;
#(
    parameter int PW = OSC_PERIOD_W
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic run,
    input wire logic [PW-1:0] period,
    output logic tick,
    output logic done
);

    logic [PW-1:0] cnt;
    logic [OSC_DIV_W-1:0] osc_cycles;

    // A period of zero behaves as one cycle rather than stalling.
    assign tick = run && (({1'b0, cnt} + (PW + 1)'(1)) >= {1'b0, period});
    assign done = tick && (osc_cycles == PULSE_LAST_OSC);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            cnt <= '0;
        else if (!run || tick)
            cnt <= '0;
        else
            cnt <= cnt + PW'(1);
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            osc_cycles <= '0;
        else if (!run)
            osc_cycles <= '0;
        else if (tick)
            osc_cycles <= osc_cycles + OSC_DIV_W'(1);
    end

endmodule // vsd_osc_div

// ---- core/vsd_pkg.sv ----
// Constants and carrier types shared by the vertical sync detector.
package vsd_pkg;

    // Datapath widths.
    localparam int VIDEO_W = 8;
    localparam int INTEG_W = 16;
    localparam int TSET_W = 8;
    localparam int GAP_W = 12;
    localparam int OSC_SHIFT = 4;
    localparam int OSC_PERIOD_W = TSET_W + OSC_SHIFT;
    localparam int OSC_DIV_W = 3;

    // Slice offset above the clamped tip, as a voltage and as a code.
    localparam int SLICE_OFFSET_MV = 70;
    localparam int VIDEO_MV_PER_LSB = 8;
    localparam logic [VIDEO_W:0] SLICE_OFFSET_CODE =
        (VIDEO_W + 1)'((SLICE_OFFSET_MV + VIDEO_MV_PER_LSB / 2) / VIDEO_MV_PER_LSB);

    // The tip reference creeps up by one code every so many cycles.
    localparam int CLAMP_LEAK_CYCLES = 64;
    localparam int LEAK_W = 6;

    // Integrator discharge per cycle while sync is inactive.
    localparam logic [INTEG_W-1:0] INTEG_DISCHARGE = 16'h0004;
    localparam logic [INTEG_W-1:0] INTEG_MAX = 16'hffff;

    // Index of the last of the eight oscillator cycles that make up one vertical pulse.
    localparam logic [OSC_DIV_W-1:0] PULSE_LAST_OSC = 3'h7;

    // Reset values.
    localparam logic [VIDEO_W-1:0] TIP_RESET = 8'hff;
    localparam logic [INTEG_W-1:0] INTEG_RESET = 16'h0000;

    // Run-time settings that travel together into the detector.
    typedef struct packed {
        logic [TSET_W-1:0] timing_set;
        logic [INTEG_W-1:0] serration_detect_threshold;
        logic [INTEG_W-1:0] default_detect_threshold;
        logic [GAP_W-1:0] field_gap_threshold;
    } vsd_cfg_t;

endpackage

// ---- tb/test_vsd_detector.sv ----
// Self-checking bench for the vertical sync detector.
`timescale 1ns/1ps
module test_vsd_detector
    import vsd_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic sync_on = 1'b1;
    // The clamp only creeps upwards, so the source starts at the highest tip tested.
    logic [VIDEO_W-1:0] tip_lvl = 8'h40;
    logic [VIDEO_W-1:0] ofs = 8'h00;
    logic [VIDEO_W-1:0] video_in;
    vsd_cfg_t cfg = '{8'h02, 16'h000a, 16'h0064, 12'h028};
    logic csync_n;
    logic vsync;
    logic field_odd;
    logic vs_q = 1'b0;
    logic fld;
    int cyc = 0;
    int t0 = 0;
    int npulse = 0;
    int rise = 0;
    int width = 0;
    int fail_count = 0;
    int num_checks = 0;

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    vsd_video_src u_src (.clk_sys(clk_sys), .sync_on(sync_on), .tip_lvl(tip_lvl),
        .ofs(ofs), .video_in(video_in));
    vsd_detector u_dut (.clk_sys(clk_sys), .nrst(nrst), .video_in(video_in), .cfg(cfg),
        .csync_n(csync_n), .vsync(vsync), .field_odd(field_odd));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Pulse edges are sampled on the falling clock, where outputs have settled.
    always @(negedge clk_sys)
    begin
        cyc = cyc + 1;
        if (cyc > 20000)
        begin
            fail_count++;
            finish_test();
        end
        if (vsync === 1'b1 && vs_q === 1'b0)
        begin
            npulse++;
            // Only the first pulse of an interval is timed; a retrigger comes later.
            if (npulse == 1)
            begin
                rise = cyc - t0;
                fld = field_odd;
            end
        end
        if (vsync === 1'b0 && vs_q === 1'b1 && npulse == 1)
            width = cyc - t0 - rise;
        vs_q = vsync;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask

    task automatic pulse(input int s, input int g);
        sync_on = 1'b1;
        step(s);
        sync_on = 1'b0;
        step(g);
    endtask

    // Normal lines, equalizing pulses, then n broad pulses of len cycles with short gaps.
    task automatic vert(input logic [7:0] ts, input int eq, input int n, input int len,
        input int en, input int lo, input int hi);
        cfg.timing_set = ts;
        repeat (4) pulse(6, 48);
        repeat (eq) pulse(3, 24);
        npulse = 0;
        t0 = cyc;
        repeat (n) pulse(len, 4);
        repeat (30) pulse(6, 48);
        check("pulse_count", npulse, en);
        if (en > 0)
        begin
            check("rise_time", rise >= lo && rise <= hi, 1'b1);
            check("pulse_width", width, 128 * ts);
            check("field_odd", fld, eq % 2);
        end
    endtask

    task automatic t_slice(input logic [7:0] tl);
        tip_lvl = tl;
        sync_on = 1'b1;
        step(3);
        check("csync_tip", csync_n, 1'b0);
        ofs = 8'h0a;
        step(2);
        check("csync_tip_10", csync_n, 1'b1);
        ofs = 8'h09;
        step(2);
        check("csync_tip_9", csync_n, 1'b0);
        ofs = 8'h00;
        sync_on = 1'b0;
        step(2);
        repeat (8)
        begin
            check("csync_picture", csync_n, 1'b1);
            step(1);
        end
        $display("test slice at tip %h done", tl);
    endtask

    task automatic t_serr_fast();
        vert(8'h02, 6, 6, 50, 2, 50, 58);
        $display("test serrated fast done");
    endtask

    task automatic t_serr_slow();
        vert(8'h04, 5, 6, 50, 1, 50, 58);
        $display("test serrated slow done");
    endtask

    task automatic t_too_slow();
        vert(8'hff, 6, 6, 50, 0, 0, 0);
        $display("test slow charge done");
    endtask

    task automatic t_default();
        vert(8'h02, 5, 1, 500, 2, 196, 210);
        $display("test default path done");
    endtask

    task automatic t_reset_mid();
        cfg.timing_set = 8'h02;
        sync_on = 1'b1;
        step(300);
        check("vsync_before_reset", vsync, 1'b1);
        nrst = 1'b0;
        #1;
        check("vsync_in_reset", vsync, 1'b0);
        check("csync_in_reset", csync_n, 1'b1);
        check("field_in_reset", field_odd, 1'b0);
        step(2);
        nrst = 1'b1;
        sync_on = 1'b0;
        step(4);
        $display("test reset mid pulse done");
    endtask

    initial
    begin
        step(4);
        check("rst_vsync", vsync, 1'b0);
        check("rst_csync", csync_n, 1'b1);
        check("rst_field", field_odd, 1'b0);
        nrst = 1'b1;
        t_slice(8'h40);
        t_slice(8'h10);
        t_serr_fast();
        t_serr_slow();
        t_too_slow();
        t_default();
        t_reset_mid();
        finish_test();
    end
endmodule // test_vsd_detector

// ---- tb/vsd_video_src.sv ----
// Behavioural composite video source that feeds the detector input.
`timescale 1ns/1ps
module vsd_video_src
    import vsd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sync_on,
    input wire logic [VIDEO_W-1:0] tip_lvl,
    input wire logic [VIDEO_W-1:0] ofs,
    output logic [VIDEO_W-1:0] video_in
);
    logic [VIDEO_W-1:0] pix = 8'h00;
    // Picture content moves every sample, so a slicer that leaks picture shows it.
    always @(posedge clk_sys)
    begin
        pix <= #2 pix + 8'h25;
    end
    assign video_in = sync_on ? tip_lvl + ofs : tip_lvl + 8'h20 + {2'h0, pix[5:0]};
endmodule // vsd_video_src
